// ===== lsil_line_status.sv
// Line status, sticky event flags, error count reporting and interrupt gating with its register slave.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module lsil_line_status #(
  parameter int ONE_SECOND_CYCLES = lsil_pkg::ONE_SECOND_CYCLES_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire lsil_pkg::lsil_bus_req_type i_bus,
  input wire lsil_pkg::lsil_line_in_type i_line,
  output logic [lsil_pkg::DATA_W-1:0] o_rdata,
  output logic o_irq
);
  import lsil_pkg::*;

  lsil_state_type s_q;
  lsil_state_type s_d;
  logic [DATA_W-1:0] line_set;
  logic [DATA_W-1:0] error_set;
  logic count_inc;
  logic second_tick;
  logic manual_rise;
  logic transfer;

  // A status change qualifies on a rise always, and on a fall only when both edges are selected.
  function automatic logic edge_hit(input logic now, input logic was, input logic both_edges);
    return (now && !was) || (both_edges && !now && was);
  endfunction : edge_hit

  // Set wins over a clear in the same cycle, so an event is never lost to a racing write.
  function automatic logic [DATA_W-1:0] sticky(input logic [DATA_W-1:0] flags, input logic [DATA_W-1:0] set,
      input logic [DATA_W-1:0] clear);
    return (flags & ~clear) | set;
  endfunction : sticky

  function automatic logic wr_hit(input lsil_bus_req_type b, input logic [ADDR_W-1:0] target);
    return b.write && (b.addr == target);
  endfunction : wr_hit

  function automatic logic rd_hit(input lsil_bus_req_type b, input logic [ADDR_W-1:0] target);
    return b.read && (b.addr == target);
  endfunction : rd_hit

  // Peak tracking restarts from the present sample after a read, a clear or the first sample after reset.
  function automatic lsil_jitter_type jitter_next(input lsil_jitter_type j, input logic [SPACING_W-1:0] sample,
      input logic restart, input logic clear);
    lsil_jitter_type n;
    n = j;
    n.primed = 1'b1;
    n.now = clear ? '0 : sample;
    if (clear || restart || !j.primed) begin
      n.high = sample;
      n.low = sample;
    end else begin
      if (sample > j.high) begin
        n.high = sample;
      end
      if (sample < j.low) begin
        n.low = sample;
      end
    end
    return n;
  endfunction : jitter_next

  function automatic logic [DATA_W-1:0] jitter_view(input lsil_jitter_type j, input logic peak);
    return DATA_W'(peak ? SPACING_W'(j.high - j.low) : j.now);
  endfunction : jitter_view

  function automatic logic [DATA_W-1:0] read_byte(input logic [ADDR_W-1:0] a, input lsil_state_type s);
    logic [DATA_W-1:0] r;
    r = '0;
    case (a)
      ADDR_TX_PEAK_CTRL: r = DATA_W'(s.tx_peak_select) << BIT_PEAK_SELECT;
      ADDR_RX_PEAK_CTRL: r = DATA_W'(s.rx_peak_select) << BIT_PEAK_SELECT;
      ADDR_COUNT_CTRL: r = s.count_ctrl;
      ADDR_LINE_ENABLE: r = s.line_enable;
      ADDR_ERROR_ENABLE: r = s.error_enable;
      ADDR_EDGE_SELECT: r = s.edge_select;
      ADDR_LINE_LIVE: begin
        r[BIT_DRIVER_FAIL] = s.driver_fail_live;
        r[BIT_SIGNAL_LOSS] = s.signal_loss_live;
      end
      ADDR_GAIN: r = DATA_W'(s.gain);
      ADDR_TX_JITTER: r = jitter_view(s.tx_jitter, s.tx_peak_select);
      ADDR_RX_JITTER: r = jitter_view(s.rx_jitter, s.rx_peak_select);
      ADDR_LINE_EVENTS: r = s.line_events;
      ADDR_ERROR_EVENTS: r = s.error_events;
      ADDR_COUNT_HIGH: r = s.report_count[COUNT_W-1 -: DATA_W];
      ADDR_COUNT_LOW: r = s.report_count[DATA_W-1:0];
      default: r = '0;
    endcase
    return r;
  endfunction : read_byte

  // Counting only runs with the select field at its enabling value.
  assign count_inc = i_line.excessive_zero_error &&
      (s_q.count_ctrl[COUNT_SELECT_LSB +: COUNT_SELECT_W] == COUNT_SELECT_ENABLE);
  assign second_tick = (s_q.second_count == SEC_W'(ONE_SECOND_CYCLES - 1));
  assign manual_rise = wr_hit(i_bus, ADDR_COUNT_CTRL) && i_bus.wdata[BIT_COUNT_TRANSFER] &&
      !s_q.count_ctrl[BIT_COUNT_TRANSFER] && !s_q.count_ctrl[BIT_COUNT_MODE];
  assign transfer = s_q.count_ctrl[BIT_COUNT_MODE] ? second_tick : manual_rise;

  always_comb begin
    s_d = s_q;
    line_set = '0;
    error_set = '0;

    s_d.driver_fail_live = i_line.driver_fail;
    s_d.signal_loss_live = i_line.signal_loss;
    s_d.gain = i_line.equalizer_gain_code;

    if (wr_hit(i_bus, ADDR_EDGE_SELECT)) begin
      s_d.edge_select = i_bus.wdata & LINE_BITS_MASK;
    end
    if (wr_hit(i_bus, ADDR_LINE_ENABLE)) begin
      s_d.line_enable = i_bus.wdata & LINE_BITS_MASK;
    end
    if (wr_hit(i_bus, ADDR_ERROR_ENABLE)) begin
      s_d.error_enable = i_bus.wdata & ERROR_BITS_MASK;
    end
    if (wr_hit(i_bus, ADDR_COUNT_CTRL)) begin
      s_d.count_ctrl = i_bus.wdata & COUNT_CTRL_MASK;
    end
    if (wr_hit(i_bus, ADDR_TX_PEAK_CTRL)) begin
      s_d.tx_peak_select = i_bus.wdata[BIT_PEAK_SELECT];
    end
    if (wr_hit(i_bus, ADDR_RX_PEAK_CTRL)) begin
      s_d.rx_peak_select = i_bus.wdata[BIT_PEAK_SELECT];
    end

    line_set[BIT_DRIVER_FAIL] = edge_hit(i_line.driver_fail, s_q.driver_fail_live,
        s_q.edge_select[BIT_DRIVER_FAIL]);
    line_set[BIT_SIGNAL_LOSS] = edge_hit(i_line.signal_loss, s_q.signal_loss_live,
        s_q.edge_select[BIT_SIGNAL_LOSS]);
    s_d.line_events = sticky(s_q.line_events, line_set,
        wr_hit(i_bus, ADDR_LINE_EVENTS) ? (i_bus.wdata & LINE_BITS_MASK) : '0);

    error_set[BIT_TEMPLATE] = i_line.template_overflow;
    error_set[BIT_TX_SLIP] = i_line.tx_fifo_slip;
    error_set[BIT_RX_SLIP] = i_line.rx_fifo_slip;
    error_set[BIT_ZERO_RUN] = i_line.excessive_zero_error;
    error_set[BIT_CODE_VIOL] = i_line.bipolar_violation;
    error_set[BIT_COUNT_OVF] = count_inc && !transfer && (s_q.zero_count == COUNT_MAX);
    s_d.error_events = sticky(s_q.error_events, error_set,
        wr_hit(i_bus, ADDR_ERROR_EVENTS) ? (i_bus.wdata & ERROR_BITS_MASK) : '0);

    // The internal count restarts on each transfer so that every report covers one interval.
    s_d.zero_count = (transfer ? '0 : s_q.zero_count) + COUNT_W'(count_inc);
    if (transfer) begin
      s_d.report_count = s_q.zero_count;
    end
    s_d.second_count = second_tick ? '0 : s_q.second_count + SEC_W'(1);

    s_d.tx_jitter = jitter_next(s_q.tx_jitter, i_line.tx_pointer_spacing, rd_hit(i_bus, ADDR_TX_JITTER),
        wr_hit(i_bus, ADDR_TX_JITTER) && (i_bus.wdata != '0));
    s_d.rx_jitter = jitter_next(s_q.rx_jitter, i_line.rx_pointer_spacing, rd_hit(i_bus, ADDR_RX_JITTER),
        wr_hit(i_bus, ADDR_RX_JITTER) && (i_bus.wdata != '0));

    s_d.rdata = i_bus.read ? read_byte(i_bus.addr, s_q) : '0;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_irq = |(s_q.line_events & s_q.line_enable) | |(s_q.error_events & s_q.error_enable);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_count_irq_gate: assert property (s_q.error_events[BIT_COUNT_OVF] && s_q.error_enable[BIT_COUNT_OVF] |-> o_irq)
    else $error("counter overflow enabled but interrupt low");
  a_irq_all_masked: assert property ((s_q.line_enable == '0) && (s_q.error_enable == '0) |-> !o_irq)
    else $error("interrupt active with every enable clear");
  a_loss_rise_latch: assert property (i_line.signal_loss && !s_q.signal_loss_live
      |=> s_q.line_events[BIT_SIGNAL_LOSS])
    else $error("signal loss rise not latched");
  a_fall_ignored_edge: assert property (!i_line.driver_fail && s_q.driver_fail_live &&
      !s_q.edge_select[BIT_DRIVER_FAIL] && !s_q.line_events[BIT_DRIVER_FAIL]
      |=> !s_q.line_events[BIT_DRIVER_FAIL])
    else $error("driver fail fall latched with rise-only select");
  a_live_follows_pin: assert property (##1 s_q.driver_fail_live == $past(i_line.driver_fail))
    else $error("driver fail live bit does not follow detector");
  a_gain_readback: assert property (i_bus.read && (i_bus.addr == ADDR_GAIN)
      |=> o_rdata == DATA_W'($past(s_q.gain)))
    else $error("gain readback mismatch");
  a_jitter_write_clear: assert property (wr_hit(i_bus, ADDR_TX_JITTER) && (i_bus.wdata != '0)
      |=> jitter_view(s_q.tx_jitter, s_q.tx_peak_select) == '0)
    else $error("tx jitter not cleared by write");
  a_event_holds: assert property (s_q.error_events[BIT_ZERO_RUN] &&
      !(wr_hit(i_bus, ADDR_ERROR_EVENTS) && i_bus.wdata[BIT_ZERO_RUN])
      |=> s_q.error_events[BIT_ZERO_RUN])
    else $error("zero run event dropped without write one");
  a_set_beats_clear: assert property (i_line.bipolar_violation && wr_hit(i_bus, ADDR_ERROR_EVENTS) &&
      i_bus.wdata[BIT_CODE_VIOL] |=> s_q.error_events[BIT_CODE_VIOL])
    else $error("code violation lost to coincident clear");
  a_count_overflow: assert property (count_inc && !transfer && (s_q.zero_count == COUNT_MAX)
      |=> s_q.error_events[BIT_COUNT_OVF] && (s_q.zero_count == '0))
    else $error("counter overflow not flagged");
  a_manual_report: assert property (manual_rise |=> ##1 s_q.report_count == $past(s_q.zero_count, 2))
    else $error("manual transfer did not copy count");
  a_report_stable: assert property (!transfer |=> $stable(s_q.report_count))
    else $error("report count changed without transfer");
  a_loss_live_pin: assert property (##1 s_q.signal_loss_live == $past(i_line.signal_loss))
    else $error("signal loss live bit does not follow detector");
  a_template_latch: assert property (i_line.template_overflow |=> s_q.error_events[BIT_TEMPLATE])
    else $error("template overflow not latched");
  a_tx_slip_latch: assert property (i_line.tx_fifo_slip |=> s_q.error_events[BIT_TX_SLIP])
    else $error("transmit fifo slip not latched");
  a_zero_run_latch: assert property (i_line.excessive_zero_error |=> s_q.error_events[BIT_ZERO_RUN])
    else $error("zero run error not latched");
  a_auto_report: assert property (s_q.count_ctrl[BIT_COUNT_MODE] && second_tick
      |=> s_q.report_count == $past(s_q.zero_count))
    else $error("automatic report did not copy count");
  a_rdata_idle: assert property (!i_bus.read |=> o_rdata == '0)
    else $error("read data shown without a read");

  c_irq_raised: cover property (!o_irq ##1 o_irq);
  c_auto_report: cover property (s_q.count_ctrl[BIT_COUNT_MODE] && second_tick);
  c_overflow_seen: cover property ($rose(s_q.error_events[BIT_COUNT_OVF]));
  c_peak_read: cover property (s_q.tx_peak_select && rd_hit(i_bus, ADDR_TX_JITTER));

endmodule : lsil_line_status

// ===== lsil_pkg.sv
// Register map, field layout, carrier types and timing constants of the line status interrupt logic.
package lsil_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int GAIN_W = 5;
  localparam int SPACING_W = 7;
  localparam int COUNT_W = 16;

  localparam logic [ADDR_W-1:0] ADDR_TX_PEAK_CTRL = 8'h21;
  localparam logic [ADDR_W-1:0] ADDR_RX_PEAK_CTRL = 8'h27;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_CTRL = 8'h31;
  localparam logic [ADDR_W-1:0] ADDR_LINE_ENABLE = 8'h33;
  localparam logic [ADDR_W-1:0] ADDR_ERROR_ENABLE = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SELECT = 8'h35;
  localparam logic [ADDR_W-1:0] ADDR_LINE_LIVE = 8'h36;
  localparam logic [ADDR_W-1:0] ADDR_GAIN = 8'h37;
  localparam logic [ADDR_W-1:0] ADDR_TX_JITTER = 8'h38;
  localparam logic [ADDR_W-1:0] ADDR_RX_JITTER = 8'h39;
  localparam logic [ADDR_W-1:0] ADDR_LINE_EVENTS = 8'h3a;
  localparam logic [ADDR_W-1:0] ADDR_ERROR_EVENTS = 8'h3b;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = 8'h3c;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = 8'h3d;

  localparam int BIT_DRIVER_FAIL = 2;
  localparam int BIT_SIGNAL_LOSS = 0;
  localparam int BIT_TEMPLATE = 6;
  localparam int BIT_TX_SLIP = 5;
  localparam int BIT_RX_SLIP = 4;
  localparam int BIT_ZERO_RUN = 2;
  localparam int BIT_CODE_VIOL = 1;
  localparam int BIT_COUNT_OVF = 0;
  localparam int BIT_PEAK_SELECT = 5;
  localparam int BIT_COUNT_MODE = 1;
  localparam int BIT_COUNT_TRANSFER = 0;
  localparam int COUNT_SELECT_LSB = 2;
  localparam int COUNT_SELECT_W = 2;

  localparam logic [DATA_W-1:0] LINE_BITS_MASK = 8'h05;
  localparam logic [DATA_W-1:0] ERROR_BITS_MASK = 8'h77;
  localparam logic [DATA_W-1:0] COUNT_CTRL_MASK = 8'h0f;
  localparam logic [COUNT_SELECT_W-1:0] COUNT_SELECT_ENABLE = 2'h1;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hffff;

  localparam longint CLK_PERIOD_NS = 40;
  localparam longint ONE_SECOND_NS = 1000000000;
  localparam int ONE_SECOND_CYCLES_DEFAULT = int'(ONE_SECOND_NS / CLK_PERIOD_NS);
  localparam int SEC_W = $clog2(ONE_SECOND_CYCLES_DEFAULT);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic write;
    logic read;
  } lsil_bus_req_type;

  typedef struct packed {
    logic driver_fail;
    logic signal_loss;
    logic [GAIN_W-1:0] equalizer_gain_code;
    logic [SPACING_W-1:0] tx_pointer_spacing;
    logic [SPACING_W-1:0] rx_pointer_spacing;
    logic template_overflow;
    logic tx_fifo_slip;
    logic rx_fifo_slip;
    logic excessive_zero_error;
    logic bipolar_violation;
  } lsil_line_in_type;

  typedef struct packed {
    logic primed;
    logic [SPACING_W-1:0] now;
    logic [SPACING_W-1:0] high;
    logic [SPACING_W-1:0] low;
  } lsil_jitter_type;

  typedef struct packed {
    logic [DATA_W-1:0] edge_select, line_enable, error_enable, count_ctrl;
    logic [DATA_W-1:0] line_events, error_events, rdata;
    logic tx_peak_select, rx_peak_select, driver_fail_live, signal_loss_live;
    logic [GAIN_W-1:0] gain;
    lsil_jitter_type tx_jitter, rx_jitter;
    logic [COUNT_W-1:0] zero_count, report_count;
    logic [SEC_W-1:0] second_count;
  } lsil_state_type;

  localparam lsil_state_type STATE_RESET = '0;

endpackage : lsil_pkg

// ===== lsil_line_status_tb.sv
// Self-checking testbench for the line status interrupt logic.
`timescale 1ns/1ps
module lsil_line_status_tb;
  import lsil_pkg::*;
  // A short second keeps the automatic report visible within a few dozen cycles.
  localparam int SEC = 20;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  lsil_bus_req_type bus = '0;
  lsil_line_in_type line = '0;
  logic [DATA_W-1:0] o_rdata;
  logic o_irq;
  int err_total = 0;
  int cmp_count = 0;

  always #20 i_clk = ~i_clk;

  lsil_line_status #(.ONE_SECOND_CYCLES(SEC)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(bus),
    .i_line(line), .o_rdata(o_rdata), .o_irq(o_irq));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step();
    @(posedge i_clk);
    bus <= '0;
  endtask : step

  task automatic idle(input int n);
    repeat (n) step();
  endtask : idle

  // Leaves the write strobe up, so a following request comes back to back.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    step();
    // Judged at the edge that closes the only cycle in which the read data stand.
    @(posedge i_clk);
    chk(o_rdata, exp);
  endtask : rd

  task automatic chk_irq(input logic exp);
    step();
    @(posedge i_clk);
    chk({7'h00, o_irq}, {7'h00, exp});
  endtask : chk_irq

  task automatic set_ev(input int b, input logic v);
    case (b)
      6: line.template_overflow <= v;
      5: line.tx_fifo_slip <= v;
      4: line.rx_fifo_slip <= v;
      2: line.excessive_zero_error <= v;
      default: line.bipolar_violation <= v;
    endcase
  endtask : set_ev

  // Each cycle with the event input high counts as one event.
  task automatic pulse(input int b, input int n);
    step();
    set_ev(b, 1'b1);
    idle(n);
    set_ev(b, 1'b0);
  endtask : pulse

  task automatic reset_values();
    logic [7:0] addrs [10] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h00, 8'hff};
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    wr(8'h3c, 8'hff);
    wr(8'h36, 8'hff);
    rd(8'h3c, 8'h00);
    rd(8'h36, 8'h00);
    chk_irq(1'b0);
  endtask : reset_values

  task automatic line_edges();
    step();
    line.driver_fail <= 1'b1;
    line.signal_loss <= 1'b1;
    idle(2);
    rd(8'h36, 8'h05);
    rd(8'h3a, 8'h05);
    chk_irq(1'b0);
    wr(8'h33, 8'h05);
    chk_irq(1'b1);
    wr(8'h3a, 8'h00);
    rd(8'h3a, 8'h05);
    wr(8'h3a, 8'h05);
    chk_irq(1'b0);
    line.driver_fail <= 1'b0;
    line.signal_loss <= 1'b0;
    idle(2);
    rd(8'h36, 8'h00);
    rd(8'h3a, 8'h00);
    wr(8'h35, 8'h05);
    line.driver_fail <= 1'b1;
    line.signal_loss <= 1'b1;
    idle(2);
    wr(8'h3a, 8'h05);
    step();
    line.driver_fail <= 1'b0;
    line.signal_loss <= 1'b0;
    idle(2);
    rd(8'h3a, 8'h05);
    wr(8'h3a, 8'h05);
    wr(8'h33, 8'h00);
    rd(8'h3a, 8'h00);
  endtask : line_edges

  task automatic error_events();
    int bits [5] = '{6, 5, 4, 2, 1};
    logic [7:0] m;
    foreach (bits[i]) begin
      m = 8'h01 << bits[i];
      pulse(bits[i], 1);
      idle(1);
      rd(8'h3b, m);
      wr(8'h34, ERROR_BITS_MASK & ~m);
      chk_irq(1'b0);
      wr(8'h34, m);
      chk_irq(1'b1);
      wr(8'h3b, m);
      rd(8'h3b, 8'h00);
      chk_irq(1'b0);
      wr(8'h34, 8'h00);
    end
  endtask : error_events

  task automatic count_report();
    pulse(2, 2);
    wr(8'h31, 8'h04);
    pulse(2, 3);
    wr(8'h31, 8'h05);
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h03);
    wr(8'h31, 8'h04);
    wr(8'h3b, 8'h04);
    pulse(2, 65536);
    idle(1);
    rd(8'h3b, 8'h05);
    chk_irq(1'b0);
    wr(8'h34, 8'h01);
    chk_irq(1'b1);
    wr(8'h3b, 8'h05);
    chk_irq(1'b0);
    wr(8'h34, 8'h00);
    wr(8'h31, 8'h05);
    rd(8'h3d, 8'h00);
    wr(8'h31, 8'h06);
    line.excessive_zero_error <= 1'b1;
    idle(3 * SEC);
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'(SEC));
    line.excessive_zero_error <= 1'b0;
    wr(8'h31, 8'h00);
    wr(8'h3b, 8'h04);
    rd(8'h3b, 8'h00);
  endtask : count_report

  task automatic set_wins();
    wr(8'h3b, 8'h02);
    line.bipolar_violation <= 1'b1;
    step();
    line.bipolar_violation <= 1'b0;
    rd(8'h3b, 8'h02);
    wr(8'h3b, 8'h02);
  endtask : set_wins

  task automatic gain_jitter();
    logic [4:0] codes [4] = '{5'h00, 5'h0a, 5'h15, 5'h1f};
    foreach (codes[i]) begin
      step();
      line.equalizer_gain_code <= codes[i];
      rd(8'h37, {3'h0, codes[i]});
    end
    line.tx_pointer_spacing <= 7'h2a;
    line.rx_pointer_spacing <= 7'h2a;
    idle(2);
    rd(8'h38, 8'h2a);
    rd(8'h39, 8'h2a);
    wr(8'h38, 8'h01);
    rd(8'h38, 8'h00);
    wr(8'h39, 8'h01);
    rd(8'h39, 8'h00);
    wr(8'h21, 8'h20);
    wr(8'h27, 8'h20);
    idle(2);
    rd(8'h38, 8'h00);
    rd(8'h39, 8'h00);
    line.tx_pointer_spacing <= 7'h10;
    line.rx_pointer_spacing <= 7'h10;
    step();
    line.tx_pointer_spacing <= 7'h30;
    line.rx_pointer_spacing <= 7'h30;
    step();
    line.tx_pointer_spacing <= 7'h20;
    line.rx_pointer_spacing <= 7'h20;
    idle(2);
    rd(8'h38, 8'h20);
    rd(8'h39, 8'h20);
  endtask : gain_jitter

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // The long overflow run dominates; the rest needs fewer than four hundred cycles.
  initial begin
    repeat (80000) @(posedge i_clk);
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    reset_values();
    line_edges();
    error_events();
    set_wins();
    gain_jitter();
    count_report();
    end_of_test();
  end
endmodule : lsil_line_status_tb
